// [core/torque_bias_pkg.sv]
// Constants shared by the torque bias generator: map, codes, limits and timing
`default_nettype none
package torque_bias_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_MODE = 8'h00;
	localparam logic [7:0] OFF_STORED1 = 8'h04;
	localparam logic [7:0] OFF_STORED2 = 8'h08;
	localparam logic [7:0] OFF_STORED3 = 8'h0C;
	localparam logic [7:0] OFF_RISE_TC = 8'h10;
	localparam logic [7:0] OFF_HOLD = 8'h14;
	localparam logic [7:0] OFF_BALANCE = 8'h18;
	localparam logic [7:0] OFF_REV_BIAS = 8'h1C;
	localparam logic [7:0] OFF_REV_GAIN = 8'h20;
	localparam logic [7:0] OFF_FWD_BIAS = 8'h24;
	localparam logic [7:0] OFF_FWD_GAIN = 8'h28;
	localparam logic [7:0] OFF_CTRL = 8'h2C;
	localparam logic [7:0] OFF_STATUS = 8'h30;
	localparam logic [7:0] OFF_BIAS_NOW = 8'h34;
	// Field positions
	localparam int CTRL_CAP_BAL_BIT = 0;
	localparam int CTRL_CAP_MAX_BIT = 1;
	// Setting codes
	localparam logic [15:0] RSV_CODE = 16'h270F;
	localparam logic [15:0] MODE_STORED = 16'h0000;
	localparam logic [15:0] MODE_LIFT_FWD = 16'h0001;
	localparam logic [15:0] MODE_LIFT_REV = 16'h0002;
	localparam logic [15:0] MODE_AUTO = 16'h0003;
	localparam logic [15:0] STORED_CENTER = 16'h03E8;
	localparam logic [15:0] STORED_MIN = 16'h0258;
	localparam logic [15:0] STORED_MAX = 16'h0578;
	localparam logic [15:0] PCT_LIMIT = 16'h0190;
	localparam logic [15:0] VOLT_FULL = 16'h03E8;
	localparam logic [15:0] TIME_MAX_MS = 16'h1388;
	// Reset values
	localparam logic [15:0] RST_SETTING = RSV_CODE;
	localparam logic [15:0] RST_FWD_BIAS = 16'h0000;
	localparam logic [15:0] RST_FWD_GAIN = 16'h0064;
	// Timing: 1 ms tick at 8 ns clock
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int FRAC_BITS = 8;
	typedef enum logic [1:0]
	{
		PH_IDLE = 2'b00,
		PH_HOLD = 2'b01,
		PH_RUN = 2'b10
	} phase_t;
endpackage
`default_nettype wire

// [core/torque_bias_generator.sv]
// Start-up torque bias generator with APB configuration
// Behaviour
// RULE_01: Mode 0..3 picks bias source; 9999 disables bias entirely.
// RULE_02: Mode 0 takes bias from one of three stored values.
// RULE_03: Lines off: none; A: first; B: second; both: third stored value.
// RULE_04: Stored values centred at 1000; 600..1400 map to -400..400 percent.
// RULE_05: Stored value 9999 means no bias for that selection.
// RULE_06: Mode 1 scales analog input by bias/gain, lifting in forward.
// RULE_07: Mode 2 scales analog input by bias/gain, lifting in reverse.
// RULE_08: Mode 3 captures bias, gain and balance voltage from actual load; code captures only in a run begun in mode 0..2 and then set to 3.
// RULE_09: Software switches mode to 1 or 2 after automatic setting.
// RULE_10: Bias passes a first-order lag of 0..5 s; 9999 means zero.
// RULE_11: Output is bias alone for hold time 0..5 s; 9999 means zero.
// RULE_12: Balanced-load voltage 0..10 V offsets analog input; 9999 means 0 V.
// RULE_13: Reverse analog bias 0..400 percent; 9999 reuses forward bias.
// RULE_14: Reverse analog gain 0..400 percent; 9999 reuses forward gain.
// RULE_15: Without pre-excitation, bias applies as the start signal rises.
// RULE_16: Filtered bias is added to speed loop torque command after start.
`default_nettype none
module torque_bias_generator #(
	parameter int TICK_CYCLES = torque_bias_pkg::TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bias_select_line_a,
	input wire logic bias_select_line_b,
	input wire logic start_cmd,
	input wire logic motor_reverse,
	input wire logic [9:0] analog_in,
	input wire logic signed [15:0] speed_torque_cmd,
	output logic signed [15:0] torque_cmd_out,
	output logic bias_active
);
	////////////////////////////////////////////////////////////////////////
	logic [15:0] mode_r, stored1_r, stored2_r, stored3_r, rise_tc_r, hold_r;
	logic [15:0] balance_r, rev_bias_r, rev_gain_r, fwd_bias_r, fwd_gain_r;
	logic auto_done_r;
	logic [31:0] prdata_r;
	torque_bias_pkg::phase_t phase_r;
	logic [16:0] tick_cnt_r;
	logic ms_tick;
	logic [15:0] hold_cnt_r;
	logic signed [31:0] filt_r;
	logic signed [15:0] filt_int;
	logic signed [15:0] torque_r;
	logic signed [15:0] bias_sel;
	logic bias_en;
	logic wr_en, rd_setup, mapped;

	function automatic logic signed [15:0] clamp_pct(input logic signed [31:0] v);
		logic signed [31:0] lim;
		lim = $signed({16'h0000, torque_bias_pkg::PCT_LIMIT});
		if (v > lim)
			clamp_pct = lim[15:0];
		else if (v < -lim)
			clamp_pct = 16'(-lim);
		else
			clamp_pct = v[15:0];
	endfunction

	function automatic logic signed [15:0] decode_stored(input logic [15:0] v);
		if (v < torque_bias_pkg::STORED_MIN || v > torque_bias_pkg::STORED_MAX)
			decode_stored = 16'h0000; // RULE_05
		else
			decode_stored = $signed(v - torque_bias_pkg::STORED_CENTER); // RULE_04
	endfunction

	function automatic logic [15:0] or_reserved(input logic [15:0] v, input logic [15:0] alt);
		or_reserved = (v == torque_bias_pkg::RSV_CODE) ? alt : v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Bias source selection
	logic [15:0] rise_b, rise_g, fall_b, fall_g, use_b, use_g, v_bal;
	logic lift_rev, use_rise;
	logic signed [31:0] analog_amt;
	assign rise_b = fwd_bias_r;
	assign rise_g = fwd_gain_r;
	assign fall_b = or_reserved(rev_bias_r, fwd_bias_r); // RULE_13
	assign fall_g = or_reserved(rev_gain_r, fwd_gain_r); // RULE_14
	assign v_bal = or_reserved(balance_r, 16'h0000); // RULE_12
	assign lift_rev = (mode_r == torque_bias_pkg::MODE_LIFT_REV);
	// Lifting direction uses the rise pair, the opposite direction the fall pair
	assign use_rise = (motor_reverse == lift_rev);
	assign use_b = use_rise ? rise_b : fall_b;
	assign use_g = use_rise ? rise_g : fall_g;

	always_comb
	begin
		logic signed [31:0] span, dv, amt;
		span = $signed({16'h0000, use_g}) - $signed({16'h0000, use_b});
		dv = $signed({22'h0, analog_in}) - $signed({16'h0000, v_bal});
		amt = $signed({16'h0000, use_b})
			+ (span * dv) / $signed({16'h0000, torque_bias_pkg::VOLT_FULL});
		analog_amt = lift_rev ? -amt : amt; // RULE_06 RULE_07
	end

	always_comb
	begin
		case (mode_r)
			torque_bias_pkg::MODE_STORED:
			begin
				case ({bias_select_line_b, bias_select_line_a}) // RULE_02 RULE_03
					2'b01: bias_sel = decode_stored(stored1_r);
					2'b10: bias_sel = decode_stored(stored2_r);
					2'b11: bias_sel = decode_stored(stored3_r);
					default: bias_sel = 16'h0000;
				endcase
			end
			torque_bias_pkg::MODE_LIFT_FWD, torque_bias_pkg::MODE_LIFT_REV:
				bias_sel = clamp_pct(analog_amt);
			default: bias_sel = 16'h0000; // RULE_01
		endcase
	end

	// Auto mode only measures, so it drives no bias
	assign bias_en = (mode_r == torque_bias_pkg::MODE_STORED)
		|| (mode_r == torque_bias_pkg::MODE_LIFT_FWD)
		|| (mode_r == torque_bias_pkg::MODE_LIFT_REV); // RULE_01 RULE_09
	assign bias_active = start_cmd && bias_en; // RULE_15

	////////////////////////////////////////////////////////////////////////
	// APB slave, zero wait states
	assign wr_en = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign prdata = prdata_r;
	always_comb
	begin
		case (paddr)
			torque_bias_pkg::OFF_MODE, torque_bias_pkg::OFF_STORED1,
			torque_bias_pkg::OFF_STORED2, torque_bias_pkg::OFF_STORED3,
			torque_bias_pkg::OFF_RISE_TC, torque_bias_pkg::OFF_HOLD,
			torque_bias_pkg::OFF_BALANCE, torque_bias_pkg::OFF_REV_BIAS,
			torque_bias_pkg::OFF_REV_GAIN, torque_bias_pkg::OFF_FWD_BIAS,
			torque_bias_pkg::OFF_FWD_GAIN, torque_bias_pkg::OFF_CTRL,
			torque_bias_pkg::OFF_STATUS, torque_bias_pkg::OFF_BIAS_NOW: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign pslverr = psel && penable && !mapped;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_r <= 32'h00000000;
		else if (rd_setup)
		begin
			case (paddr)
				torque_bias_pkg::OFF_MODE: prdata_r <= {16'h0000, mode_r};
				torque_bias_pkg::OFF_STORED1: prdata_r <= {16'h0000, stored1_r};
				torque_bias_pkg::OFF_STORED2: prdata_r <= {16'h0000, stored2_r};
				torque_bias_pkg::OFF_STORED3: prdata_r <= {16'h0000, stored3_r};
				torque_bias_pkg::OFF_RISE_TC: prdata_r <= {16'h0000, rise_tc_r};
				torque_bias_pkg::OFF_HOLD: prdata_r <= {16'h0000, hold_r};
				torque_bias_pkg::OFF_BALANCE: prdata_r <= {16'h0000, balance_r};
				torque_bias_pkg::OFF_REV_BIAS: prdata_r <= {16'h0000, rev_bias_r};
				torque_bias_pkg::OFF_REV_GAIN: prdata_r <= {16'h0000, rev_gain_r};
				torque_bias_pkg::OFF_FWD_BIAS: prdata_r <= {16'h0000, fwd_bias_r};
				torque_bias_pkg::OFF_FWD_GAIN: prdata_r <= {16'h0000, fwd_gain_r};
				torque_bias_pkg::OFF_STATUS: prdata_r <= {24'h000000, bias_select_line_b,
					bias_select_line_a, start_cmd, bias_active, auto_done_r, 1'b0, phase_r};
				torque_bias_pkg::OFF_BIAS_NOW: prdata_r <= {{16{filt_int[15]}}, filt_int};
				default: prdata_r <= 32'h00000000;
			endcase
		end
	end

	// Settings; auto capture writes the analog pair and balance point
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_r <= torque_bias_pkg::RST_SETTING;
			stored1_r <= torque_bias_pkg::RST_SETTING;
			stored2_r <= torque_bias_pkg::RST_SETTING;
			stored3_r <= torque_bias_pkg::RST_SETTING;
			rise_tc_r <= torque_bias_pkg::RST_SETTING;
			hold_r <= torque_bias_pkg::RST_SETTING;
			balance_r <= torque_bias_pkg::RST_SETTING;
			rev_bias_r <= torque_bias_pkg::RST_SETTING;
			rev_gain_r <= torque_bias_pkg::RST_SETTING;
			fwd_bias_r <= torque_bias_pkg::RST_FWD_BIAS;
			fwd_gain_r <= torque_bias_pkg::RST_FWD_GAIN;
			auto_done_r <= 1'b0;
		end
		else if (wr_en)
		begin
			case (paddr)
				torque_bias_pkg::OFF_MODE:
				begin
					mode_r <= pwdata[15:0];
					auto_done_r <= 1'b0;
				end
				torque_bias_pkg::OFF_STORED1: stored1_r <= pwdata[15:0];
				torque_bias_pkg::OFF_STORED2: stored2_r <= pwdata[15:0];
				torque_bias_pkg::OFF_STORED3: stored3_r <= pwdata[15:0];
				torque_bias_pkg::OFF_RISE_TC: rise_tc_r <= pwdata[15:0];
				torque_bias_pkg::OFF_HOLD: hold_r <= pwdata[15:0];
				torque_bias_pkg::OFF_BALANCE: balance_r <= pwdata[15:0];
				torque_bias_pkg::OFF_REV_BIAS: rev_bias_r <= pwdata[15:0];
				torque_bias_pkg::OFF_REV_GAIN: rev_gain_r <= pwdata[15:0];
				torque_bias_pkg::OFF_FWD_BIAS: fwd_bias_r <= pwdata[15:0];
				torque_bias_pkg::OFF_FWD_GAIN: fwd_gain_r <= pwdata[15:0];
				torque_bias_pkg::OFF_CTRL:
				begin
					// Captures only while running under load in auto mode
					if (mode_r == torque_bias_pkg::MODE_AUTO && phase_r == torque_bias_pkg::PH_RUN)
					begin
						if (pwdata[torque_bias_pkg::CTRL_CAP_BAL_BIT])
						begin
							balance_r <= {6'h00, analog_in}; // RULE_08
							fwd_bias_r <= 16'(clamp_pct(32'(speed_torque_cmd)));
						end
						if (pwdata[torque_bias_pkg::CTRL_CAP_MAX_BIT])
						begin
							fwd_gain_r <= 16'(clamp_pct(32'(speed_torque_cmd))); // RULE_08
							auto_done_r <= 1'b1;
						end
					end
				end
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Millisecond tick
	assign ms_tick = (tick_cnt_r == 17'(TICK_CYCLES - 1));
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tick_cnt_r <= 17'h00000;
		else if (ms_tick)
			tick_cnt_r <= 17'h00000;
		else
			tick_cnt_r <= tick_cnt_r + 17'h00001;
	end

	// Start phase sequencing
	logic [15:0] hold_ms;
	assign hold_ms = or_reserved(hold_r, 16'h0000); // RULE_11
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase_r <= torque_bias_pkg::PH_IDLE;
			hold_cnt_r <= 16'h0000;
		end
		else
		begin
			case (phase_r)
				torque_bias_pkg::PH_IDLE:
				begin
					hold_cnt_r <= 16'h0000;
					if (bias_active)
						phase_r <= (hold_ms == 16'h0000) ? torque_bias_pkg::PH_RUN
							: torque_bias_pkg::PH_HOLD; // RULE_11
				end
				torque_bias_pkg::PH_HOLD:
				begin
					if (!start_cmd)
						phase_r <= torque_bias_pkg::PH_IDLE;
					else if (ms_tick)
					begin
						hold_cnt_r <= hold_cnt_r + 16'h0001;
						if (hold_cnt_r + 16'h0001 >= hold_ms)
							phase_r <= torque_bias_pkg::PH_RUN; // RULE_11
					end
				end
				torque_bias_pkg::PH_RUN:
				begin
					if (!start_cmd)
						phase_r <= torque_bias_pkg::PH_IDLE;
				end
				default: phase_r <= torque_bias_pkg::PH_IDLE;
			endcase
		end
	end

	// First-order lag in fixed point; divides once per ms tick
	logic [15:0] tc_ms;
	logic signed [31:0] target_fx;
	assign tc_ms = or_reserved(rise_tc_r, 16'h0000); // RULE_10
	assign target_fx = $signed({{16{bias_sel[15]}}, bias_sel}) <<< torque_bias_pkg::FRAC_BITS;
	assign filt_int = filt_r[torque_bias_pkg::FRAC_BITS +: 16];
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			filt_r <= 32'h00000000;
		else if (!bias_active)
			filt_r <= 32'h00000000;
		else if (tc_ms == 16'h0000)
			filt_r <= target_fx; // RULE_10 RULE_15
		else if (ms_tick)
			filt_r <= filt_r + (target_fx - filt_r) / $signed({16'h0000, tc_ms}); // RULE_10
	end

	// Torque command out: bias alone in hold, speed command plus bias in run
	assign torque_cmd_out = torque_r;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			torque_r <= 16'h0000;
		else
		begin
			case (phase_r)
				torque_bias_pkg::PH_HOLD: torque_r <= filt_int; // RULE_11
				torque_bias_pkg::PH_RUN:
					torque_r <= clamp_pct(32'(speed_torque_cmd) + 32'(filt_int)); // RULE_16
				default: torque_r <= speed_torque_cmd;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_mode_off;
		(mode_r == torque_bias_pkg::RSV_CODE) |-> (bias_sel == 16'h0000) && !bias_active;
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("bias with mode disabled"); // RULE_01

	property p_sel_none;
		(mode_r == torque_bias_pkg::MODE_STORED && !bias_select_line_a && !bias_select_line_b)
			|-> bias_sel == 16'h0000;
	endproperty
	a_sel_none: assert property (p_sel_none) else $error("bias with no line"); // RULE_03

	property p_sel_third;
		(mode_r == torque_bias_pkg::MODE_STORED && bias_select_line_a && bias_select_line_b
			&& stored3_r >= torque_bias_pkg::STORED_MIN
			&& stored3_r <= torque_bias_pkg::STORED_MAX)
			|-> bias_sel == $signed(stored3_r - torque_bias_pkg::STORED_CENTER);
	endproperty
	a_sel_third: assert property (p_sel_third) else $error("third value misdecoded"); // RULE_04

	property p_stored_rsv;
		(mode_r == torque_bias_pkg::MODE_STORED && bias_select_line_a && !bias_select_line_b
			&& stored1_r == torque_bias_pkg::RSV_CODE) |-> bias_sel == 16'h0000;
	endproperty
	a_stored_rsv: assert property (p_stored_rsv) else $error("reserved stored value used"); // RULE_05

	property p_rev_fallback;
		(rev_bias_r == torque_bias_pkg::RSV_CODE && rev_gain_r == torque_bias_pkg::RSV_CODE)
			|-> fall_b == fwd_bias_r && fall_g == fwd_gain_r;
	endproperty
	a_rev_fallback: assert property (p_rev_fallback) else $error("fall pair not reused"); // RULE_13

	property p_lag_zero;
		(bias_active && tc_ms == 16'h0000) |=> (filt_int == $past(bias_sel)) || !bias_active;
	endproperty
	a_lag_zero: assert property (p_lag_zero) else $error("zero lag not immediate"); // RULE_10

	property p_start_now;
		$rose(start_cmd) && bias_en && phase_r == torque_bias_pkg::PH_IDLE
			|-> bias_active ##1 phase_r != torque_bias_pkg::PH_IDLE;
	endproperty
	a_start_now: assert property (p_start_now) else $error("bias late at start"); // RULE_15

	property p_hold_zero;
		(phase_r == torque_bias_pkg::PH_IDLE && bias_active && hold_ms == 16'h0000)
			|=> phase_r == torque_bias_pkg::PH_RUN;
	endproperty
	a_hold_zero: assert property (p_hold_zero) else $error("zero hold not skipped"); // RULE_11

	property p_hold_out;
		(phase_r == torque_bias_pkg::PH_HOLD) |=> torque_cmd_out == $past(filt_int);
	endproperty
	a_hold_out: assert property (p_hold_out) else $error("hold output not bias"); // RULE_11

	property p_run_sum;
		(phase_r == torque_bias_pkg::PH_RUN) |=>
			torque_cmd_out == clamp_pct(32'($past(speed_torque_cmd)) + 32'($past(filt_int)));
	endproperty
	a_run_sum: assert property (p_run_sum) else $error("run output not summed"); // RULE_16

	c_stored_run: cover property (mode_r == torque_bias_pkg::MODE_STORED
		&& phase_r == torque_bias_pkg::PH_RUN && filt_int != 16'h0000);
	c_hold_run: cover property (phase_r == torque_bias_pkg::PH_HOLD
		##1 phase_r == torque_bias_pkg::PH_RUN);
	c_analog_rev: cover property (lift_rev && bias_active && !use_rise);
	c_auto_done: cover property ($rose(auto_done_r));
endmodule
`default_nettype wire

// [verification/drive_side_model.sv]
// Behavioural model of the drive side: contacts, start, motion and speed loop
`default_nettype none
module drive_side_model (
	input wire logic pclk,
	output logic bias_select_line_a,
	output logic bias_select_line_b,
	output logic start_cmd,
	output logic motor_reverse,
	output logic [9:0] analog_in,
	output logic signed [15:0] speed_torque_cmd
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		bias_select_line_a = 1'b0;
		bias_select_line_b = 1'b0;
		start_cmd = 1'b0;
		motor_reverse = 1'b0;
		analog_in = 10'h000;
		speed_torque_cmd = 16'sh0000;
	end
	////////////////////////////////////////////////////////////////////////////
	// Every change lands just after a rising edge, as a real drive would
	task automatic set_contacts(input logic a, input logic b);
		@(posedge pclk);
		bias_select_line_a <= a;
		bias_select_line_b <= b;
	endtask
	task automatic set_start(input logic s);
		@(posedge pclk);
		start_cmd <= s;
	endtask
	// Speed command is not cleared between starts, so stale values show
	task automatic set_motion(input logic rev, input int spd, input int volt);
		@(posedge pclk);
		motor_reverse <= rev;
		speed_torque_cmd <= 16'(spd);
		analog_in <= 10'(volt);
	endtask
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the torque bias generator
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn;
	logic [7:0] paddr;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic bias_select_line_a, bias_select_line_b, start_cmd, motor_reverse, bias_active;
	logic [9:0] analog_in;
	logic signed [15:0] speed_torque_cmd;
	logic signed [15:0] torque_cmd_out;
	int miscompares = 0;
	int cmp_count = 0;
	logic [31:0] rv;
	logic er;
	int md[6] = '{1, 1, 1, 1, 2, 2};
	int rvs[6] = '{0, 1, 1, 1, 1, 0};
	int bl[6] = '{9999, 9999, 9999, 250, 250, 250};
	int rb[6] = '{9999, 9999, 20, 20, 20, 20};
	int rg[6] = '{9999, 9999, 220, 220, 220, 220};
	int ex[6] = '{60, 60, 120, 70, -35, -70};
	int st[2][3] = '{'{1025, 975, 925}, '{1400, 600, 9999}};
	int sx[2][4] = '{'{0, 25, -25, -75}, '{0, 400, -400, 0}};
	always #4 pclk = ~pclk;
	torque_bias_generator #(.TICK_CYCLES(10)) u_torque_bias_generator (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bias_select_line_a(bias_select_line_a), .bias_select_line_b(bias_select_line_b),
		.start_cmd(start_cmd), .motor_reverse(motor_reverse), .analog_in(analog_in),
		.speed_torque_cmd(speed_torque_cmd), .torque_cmd_out(torque_cmd_out),
		.bias_active(bias_active));
	drive_side_model u_drive_side_model (.pclk(pclk), .bias_select_line_a(bias_select_line_a),
		.bias_select_line_b(bias_select_line_b), .start_cmd(start_cmd),
		.motor_reverse(motor_reverse), .analog_in(analog_in),
		.speed_torque_cmd(speed_torque_cmd));
	////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// Bounded wait on pready; the slave's latency is not assumed
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			miscompares++;
			tally_and_finish();
		end
		else
		begin
			rv = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task automatic wr(input logic [7:0] a, input int d);
		apb(a, 1'b1, 32'(d));
	endtask
	task automatic rd_chk(input logic [7:0] a, input int d);
		apb(a, 1'b0, 32'h00000000);
		check(rv, 32'(d));
		check({31'h00000000, er}, 32'h00000000);
	endtask
	// Start, look at bias_active at once, then at the output two edges on
	task automatic run_start(input int exp_out, input logic exp_act);
		u_drive_side_model.set_start(1'b1);
		#1;
		check({31'h00000000, bias_active}, {31'h00000000, exp_act});
		repeat (2) @(posedge pclk);
		#1;
		check(32'(torque_cmd_out), 32'(exp_out));
		u_drive_side_model.set_start(1'b0);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		presetn <= 1'b0;
		paddr <= 8'h00;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		pwdata <= 32'h00000000;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a <= 32; a += 4)
			rd_chk(8'(a), 9999);
		rd_chk(torque_bias_pkg::OFF_FWD_BIAS, 0);
		rd_chk(torque_bias_pkg::OFF_FWD_GAIN, 100);
		apb(8'h3C, 1'b0, 32'h00000000);
		check({31'h00000000, er}, 32'h00000001);
		check(rv, 32'h00000000);
		wr(torque_bias_pkg::OFF_STATUS, 32'h0000FFFF);
		rd_chk(torque_bias_pkg::OFF_STATUS, 0);
		u_drive_side_model.set_motion(1'b0, 40, 0);
		run_start(40, 1'b0);
		$display("test registers done");
		wr(torque_bias_pkg::OFF_MODE, 0);
		// First stored set runs on a speed command of 30
		u_drive_side_model.set_motion(1'b0, 30, 0);
		for (int s = 0; s < 2; s++)
		begin
			for (int k = 0; k < 3; k++)
				wr(8'(4 + 4 * k), st[s][k]);
			for (int i = 0; i < 4; i++)
			begin
				u_drive_side_model.set_contacts(i[0], i[1]);
				run_start(30 * (1 - s) + sx[s][i], 1'b1);
			end
			u_drive_side_model.set_motion(1'b0, 0, 0);
		end
		// Sum beyond the limit must saturate
		wr(torque_bias_pkg::OFF_STORED1, 1025);
		u_drive_side_model.set_contacts(1'b1, 1'b0);
		u_drive_side_model.set_motion(1'b0, 390, 0);
		run_start(400, 1'b1);
		$display("test stored done");
		wr(torque_bias_pkg::OFF_FWD_BIAS, 10);
		wr(torque_bias_pkg::OFF_FWD_GAIN, 110);
		for (int i = 0; i < 6; i++)
		begin
			u_drive_side_model.set_motion(rvs[i][0], 0, 500);
			wr(torque_bias_pkg::OFF_MODE, md[i]);
			wr(torque_bias_pkg::OFF_BALANCE, bl[i]);
			wr(torque_bias_pkg::OFF_REV_BIAS, rb[i]);
			wr(torque_bias_pkg::OFF_REV_GAIN, rg[i]);
			run_start(ex[i], 1'b1);
		end
		$display("test analog done");
		wr(torque_bias_pkg::OFF_MODE, 1);
		wr(torque_bias_pkg::OFF_BALANCE, 9999);
		wr(torque_bias_pkg::OFF_HOLD, 3);
		u_drive_side_model.set_motion(1'b0, 50, 500);
		u_drive_side_model.set_start(1'b1);
		repeat (3) @(posedge pclk);
		#1;
		check(32'(torque_cmd_out), 32'(60));
		apb(torque_bias_pkg::OFF_STATUS, 1'b0, 32'h00000000);
		check(rv & 32'h00000003, 32'h00000001);
		repeat (40) @(posedge pclk);
		#1;
		check(32'(torque_cmd_out), 32'(110));
		u_drive_side_model.set_start(1'b0);
		wr(torque_bias_pkg::OFF_HOLD, 0);
		$display("test hold done");
		// Slow lag: the bias must still be short of its target early on
		wr(torque_bias_pkg::OFF_MODE, 0);
		wr(torque_bias_pkg::OFF_RISE_TC, 4);
		wr(torque_bias_pkg::OFF_STORED1, 1100);
		u_drive_side_model.set_motion(1'b0, 0, 0);
		u_drive_side_model.set_start(1'b1);
		apb(torque_bias_pkg::OFF_BIAS_NOW, 1'b0, 32'h00000000);
		check({31'h00000000, $signed(rv) < 100 && $signed(rv) >= 0}, 32'h00000001);
		repeat (1200) @(posedge pclk);
		apb(torque_bias_pkg::OFF_BIAS_NOW, 1'b0, 32'h00000000);
		check({31'h00000000, $signed(rv) >= 99 && $signed(rv) <= 100}, 32'h00000001);
		u_drive_side_model.set_start(1'b0);
		wr(torque_bias_pkg::OFF_RISE_TC, 9999);
		$display("test filter done");
		wr(torque_bias_pkg::OFF_MODE, 1);
		u_drive_side_model.set_motion(1'b0, 80, 300);
		u_drive_side_model.set_start(1'b1);
		repeat (3) @(posedge pclk);
		wr(torque_bias_pkg::OFF_MODE, 3);
		wr(torque_bias_pkg::OFF_CTRL, 1);
		rd_chk(torque_bias_pkg::OFF_BALANCE, 300);
		rd_chk(torque_bias_pkg::OFF_FWD_BIAS, 80);
		u_drive_side_model.set_motion(1'b0, 150, 300);
		wr(torque_bias_pkg::OFF_CTRL, 2);
		rd_chk(torque_bias_pkg::OFF_FWD_GAIN, 150);
		apb(torque_bias_pkg::OFF_STATUS, 1'b0, 32'h00000000);
		check(rv & 32'h00000008, 32'h00000008);
		wr(torque_bias_pkg::OFF_MODE, 1);
		apb(torque_bias_pkg::OFF_STATUS, 1'b0, 32'h00000000);
		check(rv & 32'h00000008, 32'h00000000);
		u_drive_side_model.set_start(1'b0);
		wr(torque_bias_pkg::OFF_MODE, 3);
		run_start(150, 1'b0);
		$display("test auto done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
